// ===== include/mem_router_pkg.sv
// Package: address map constants for the memory address router
package mem_router_pkg;

	// ==========================================================
	// Address widths
	localparam int PROG_ADDR_W  = 21;
	localparam int DATA_ADDR_W  = 22;
	localparam int COP_ADDR_W   = 16;
	localparam int EXT_ADDR_W   = 24;

	// ==========================================================
	// Program space split (byte-address view of the word space)
	localparam logic [21:0] PROG_INT_LIMIT = 22'h3F_BFFF;
	localparam logic [21:0] PROG_INT_START = 22'h3F_C000;

	// ==========================================================
	// Data space split
	localparam int DATA_INT_BIT = 21;

	// ==========================================================
	// Coprocessor memory areas (words)
	localparam logic [15:0] COP_X_WORDS = 16'h4000;
	localparam logic [15:0] COP_Y_WORDS = 16'h2000;

	// Internal data memory window below the top bit (72K byte)
	localparam logic [20:0] DATA_INT_BYTES = 21'h01_2000;

	// ==========================================================
	// External space: lower half static RAM, upper half SDRAM
	localparam int EXT_HALF_BIT = 23;
	localparam logic [23:0] SRAM_BANK_MIN = 24'h04_0000;
	localparam logic [23:0] SRAM_BANK_MAX = 24'h20_0000;
	localparam logic [23:0] EXT_HALF_WORDS = 24'h80_0000;

	// Status word position of the fast interrupt enable bit
	localparam int FIQ_EN_POS = 0;

	// Status word reset value
	localparam logic [15:0] STATUS_RESET = 16'h0080;

endpackage

// ===== hw/ext_addr_former.sv
// Forms an external memory address from a window base and a local offset
`timescale 1ns/10ps
module ext_addr_former #(
	parameter int OFFS_W = 12
) (
	// Clock and reset
	input  wire logic                  clk_sys,
	input  wire logic                  rstSync_n,
	// Base pointer load
	input  wire logic                  baseWrite,
	input  wire logic [23:0]           baseData,
	// Request
	input  wire logic                  reqValid,
	input  wire logic [OFFS_W-1:0]     reqOffset,
	input  wire logic [23:0]           sramBankWords,
	// Result
	output logic      [23:0]           base,
	output logic      [23:0]           extAddr,
	output logic                       extSdram,
	output logic                       extValid,
	output logic                       extBankErr
);

	logic [23:0] sum;

	always_ff @(posedge clk_sys or negedge rstSync_n)
	begin
		if (!rstSync_n)
			base <= 24'h00_0000;
		else if (baseWrite)
			base <= baseData;
	end

	// Offset added onto the base reaches all of the external space
	assign sum = base + {{(24-OFFS_W){1'b0}}, reqOffset};

	always_ff @(posedge clk_sys or negedge rstSync_n)
	begin
		if (!rstSync_n)
		begin
			extAddr    <= 24'h00_0000;
			extSdram   <= 1'b0;
			extValid   <= 1'b0;
			extBankErr <= 1'b0;
		end
		else
		begin
			extValid   <= reqValid;
			extAddr    <= sum;
			extSdram   <= sum[mem_router_pkg::EXT_HALF_BIT];
			// Static RAM half only decodes up to the configured bank size
			extBankErr <= reqValid && !sum[mem_router_pkg::EXT_HALF_BIT]
				&& (sum >= sramBankWords);
		end
	end

endmodule

// ===== hw/memory_address_router.sv
// Memory address router: steers core, coprocessor and mover accesses
`timescale 1ns/10ps
module memory_address_router #(
	parameter int CACHE_OFFS_W = 12
) (
	// Clock and reset
	input  wire logic                  clk_sys,
	input  wire logic                  rst_n,
	// Core program fetch
	input  wire logic                  progReq,
	input  wire logic [20:0]           program_word_addr,
	output logic                       progToInternal,
	output logic                       progToCache,
	// Core data access
	input  wire logic                  dataReq,
	input  wire logic [21:0]           byte_addr_lines,
	output logic                       dataToInternal,
	output logic                       dataToCache,
	// Coprocessor data access
	input  wire logic                  copReq,
	input  wire logic                  copSelY,
	input  wire logic [15:0]           copAddr,
	output logic                       copToX,
	output logic                       copToY,
	// Status word of the core
	input  wire logic [15:0]           status_word,
	// Fast interrupt
	output logic                       fast_irq,
	output logic                       violationTaken,
	input  wire logic                  fastIrqAck,
	// Cache base pointers
	input  wire logic                  icBaseWrite,
	input  wire logic                  dcBaseWrite,
	input  wire logic [23:0]           baseData,
	output logic      [23:0]           instr_cache_window_base,
	output logic      [23:0]           data_cache_window_base,
	// External configuration and addresses
	input  wire logic [1:0]            sramBankSel,
	input  wire logic                  icMiss,
	input  wire logic [CACHE_OFFS_W-1:0] icMissOffs,
	input  wire logic                  dcMiss,
	input  wire logic [CACHE_OFFS_W-1:0] dcMissOffs,
	output logic      [23:0]           icExtAddr,
	output logic                       icExtSdram,
	output logic                       icExtValid,
	output logic      [23:0]           dcExtAddr,
	output logic                       dcExtSdram,
	output logic                       dcExtValid,
	// Movers
	input  wire logic                  data_side_mover,
	input  wire logic                  y_side_mover,
	input  wire logic                  moverToExt,
	output logic                       moverIntRead,
	output logic                       moverIntWrite,
	output logic                       moverExtRead,
	output logic                       moverExtWrite
);

	// ==========================================================
	// Reset release
	logic rstMeta_n;
	logic rstSync_n;

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rstMeta_n <= 1'b0;
			rstSync_n <= 1'b0;
		end
		else
		begin
			rstMeta_n <= 1'b1;
			rstSync_n <= rstMeta_n;
		end
	end

	// ==========================================================
	// Program decode
	logic [21:0] progByteAddr;

	// Word address shown as byte address so the split constants apply
	assign progByteAddr = {program_word_addr, 1'b0};

	always_comb
	begin
		progToInternal = progReq && (progByteAddr > mem_router_pkg::PROG_INT_LIMIT);
		progToCache    = progReq && (progByteAddr < mem_router_pkg::PROG_INT_START);
	end

	// ==========================================================
	// Core data decode
	logic dataHole;

	always_comb
	begin
		dataToInternal = dataReq && byte_addr_lines[mem_router_pkg::DATA_INT_BIT];
		dataToCache    = dataReq && !byte_addr_lines[mem_router_pkg::DATA_INT_BIT];
		// Above the 72K internal block nothing answers
		dataHole = dataReq && byte_addr_lines[mem_router_pkg::DATA_INT_BIT]
			&& (byte_addr_lines[20:0] >= mem_router_pkg::DATA_INT_BYTES);
	end

	// ==========================================================
	// Coprocessor decode
	logic copHole;

	always_comb
	begin
		copToX  = copReq && !copSelY && (copAddr < mem_router_pkg::COP_X_WORDS);
		copToY  = copReq && copSelY && (copAddr < mem_router_pkg::COP_Y_WORDS);
		copHole = copReq && !copToX && !copToY;
	end

	// ==========================================================
	// Fast interrupt
	logic fastEnable;

	assign fastEnable = status_word[mem_router_pkg::FIQ_EN_POS];

	// Request stays pending until acknowledged; a new hole wins over the ack
	always_ff @(posedge clk_sys or negedge rstSync_n)
	begin
		if (!rstSync_n)
			fast_irq <= 1'b0;
		else if (copHole || dataHole)
			fast_irq <= 1'b1;
		else if (fastIrqAck)
			fast_irq <= 1'b0;
	end

	// Routine entry only counts while the enable bit is set
	assign violationTaken = fast_irq && fastEnable;

	// ==========================================================
	// External address forming
	logic [23:0] sramBankWords;
	logic        icBankErr;
	logic        dcBankErr;

	always_comb
	begin
		case (sramBankSel)
			2'b00: sramBankWords = mem_router_pkg::SRAM_BANK_MIN;
			2'b01: sramBankWords = mem_router_pkg::SRAM_BANK_MIN << 1;
			2'b10: sramBankWords = mem_router_pkg::SRAM_BANK_MIN << 2;
			default: sramBankWords = mem_router_pkg::SRAM_BANK_MAX;
		endcase
	end

	ext_addr_former #(
		.OFFS_W        (CACHE_OFFS_W)
	) icFormer (
		.clk_sys       (clk_sys),
		.rstSync_n     (rstSync_n),
		.baseWrite     (icBaseWrite),
		.baseData      (baseData),
		.reqValid      (icMiss),
		.reqOffset     (icMissOffs),
		.sramBankWords (sramBankWords),
		.base          (instr_cache_window_base),
		.extAddr       (icExtAddr),
		.extSdram      (icExtSdram),
		.extValid      (icExtValid),
		.extBankErr    (icBankErr)
	);

	ext_addr_former #(
		.OFFS_W        (CACHE_OFFS_W)
	) dcFormer (
		.clk_sys       (clk_sys),
		.rstSync_n     (rstSync_n),
		.baseWrite     (dcBaseWrite),
		.baseData      (baseData),
		.reqValid      (dcMiss),
		.reqOffset     (dcMissOffs),
		.sramBankWords (sramBankWords),
		.base          (data_cache_window_base),
		.extAddr       (dcExtAddr),
		.extSdram      (dcExtSdram),
		.extValid      (dcExtValid),
		.extBankErr    (dcBankErr)
	);

	// ==========================================================
	// Movers
	logic moverAct;

	assign moverAct = data_side_mover || y_side_mover;

	always_comb
	begin
		moverIntRead  = moverAct && moverToExt;
		moverExtWrite = moverAct && moverToExt;
		moverExtRead  = moverAct && !moverToExt;
		moverIntWrite = moverAct && !moverToExt;
	end

	// ==========================================================
	// Checks
	AST_PROG_INT: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
		progReq && program_word_addr >= 21'h1F_E000 |-> progToInternal && !progToCache)
		else $error("high fetch not internal");
	AST_PROG_CACHE: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
		progReq && program_word_addr < 21'h1F_E000 |-> progToCache && !progToInternal)
		else $error("low fetch not cached");
	AST_PROG_IDLE: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
		!progReq |-> !progToInternal && !progToCache)
		else $error("fetch steered without request");
	AST_DATA_SEL: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
		dataReq |-> (dataToInternal == byte_addr_lines[21]) && (dataToCache != dataToInternal))
		else $error("data select wrong");
	AST_DATA_IDLE: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
		!dataReq |-> !dataToInternal && !dataToCache)
		else $error("data steered without request");
	AST_COP_X_SEL: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
		copReq && !copSelY && copAddr < 16'h4000 |-> copToX && !copToY)
		else $error("coprocessor X select wrong");
	AST_COP_Y_SEL: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
		copReq && copSelY && copAddr < 16'h2000 |-> copToY && !copToX)
		else $error("coprocessor Y select wrong");

	// Fast interrupt: a hole in the ack cycle keeps the request up
	AST_COP_FIQ: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
		copReq && !copSelY && copAddr >= 16'h4000 |=> fast_irq)
		else $error("coprocessor hole missed");
	AST_COP_Y_FIQ: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
		copReq && copSelY && copAddr >= 16'h2000 |=> fast_irq)
		else $error("coprocessor Y hole missed");
	AST_CORE_FIQ: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
		dataReq && byte_addr_lines[21] && byte_addr_lines[20:0] >= 21'h01_2000 |=> fast_irq)
		else $error("core hole missed");
	AST_FIQ_QUIET: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
		!fast_irq && !copReq && !dataReq |=> !fast_irq)
		else $error("fast interrupt without hole");
	AST_FIQ_HOLD: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
		fast_irq && !fastIrqAck |=> fast_irq)
		else $error("fast interrupt dropped before ack");
	AST_FIQ_CLEAR: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
		fast_irq && fastIrqAck && !copReq && !dataReq |=> !fast_irq)
		else $error("fast interrupt not cleared");
	AST_FIQ_GATE: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
		violationTaken |-> fast_irq && status_word[0])
		else $error("violation taken while disabled");
	AST_FIQ_TAKE: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
		fast_irq && status_word[0] |-> violationTaken)
		else $error("violation not taken while enabled");

	// External addresses
	AST_IC_BASE: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
		icBaseWrite |=> instr_cache_window_base == $past(baseData))
		else $error("program base not loaded");
	AST_DC_BASE: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
		dcBaseWrite |=> data_cache_window_base == $past(baseData))
		else $error("data base not loaded");
	AST_IC_EXT: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
		icMiss && !icBaseWrite |=> icExtValid
		&& icExtAddr == $past(instr_cache_window_base) + 24'($past(icMissOffs)))
		else $error("program ext address wrong");
	AST_DC_EXT: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
		dcMiss |=> dcExtValid
		&& dcExtAddr == $past(data_cache_window_base) + 24'($past(dcMissOffs)))
		else $error("data ext address wrong");
	AST_IC_IDLE: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
		!icMiss |=> !icExtValid)
		else $error("program ext result without miss");
	AST_DC_IDLE: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
		!dcMiss |=> !dcExtValid)
		else $error("data ext result without miss");
	AST_IC_HALF: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
		icExtValid |-> icExtSdram == icExtAddr[23])
		else $error("program external half wrong");
	AST_DC_HALF: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
		dcExtValid |-> dcExtSdram == dcExtAddr[23])
		else $error("external half wrong");
	// Bank limit is the size selected in the cycle the miss was taken
	AST_IC_BANK: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
		icExtValid |-> icBankErr == (!icExtSdram
		&& icExtAddr >= (mem_router_pkg::SRAM_BANK_MIN << $past(sramBankSel))))
		else $error("program bank error wrong");
	AST_DC_BANK: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
		dcExtValid |-> dcBankErr == (!dcExtSdram
		&& dcExtAddr >= (mem_router_pkg::SRAM_BANK_MIN << $past(sramBankSel))))
		else $error("data bank error wrong");

	// Movers
	AST_MOVER: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
		moverAct |-> (moverIntRead ^ moverIntWrite) && (moverIntRead == moverExtWrite))
		else $error("mover direction wrong");
	AST_MOVER_IDLE: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
		!moverAct |-> !moverIntRead && !moverIntWrite && !moverExtRead && !moverExtWrite)
		else $error("mover strobe while idle");

endmodule

// ===== verification/core_model.sv
// Core-side partner: owns the status word and acknowledges the fast interrupt
`timescale 1ns/10ps
module core_model (
	// Clock
	input  wire logic        clk_sys,
	// Bench control
	input  wire logic        irqEn,
	input  wire logic [3:0]  ackDelay,
	// Router side
	input  wire logic        violationTaken,
	output logic      [15:0] status_word,
	output logic             fastIrqAck
);
	logic [3:0] waitCnt = 4'h0;
	initial fastIrqAck = 1'b0;
	// Privilege bit kept set so the enable bit may be changed
	assign status_word = {9'h001, 6'h00, irqEn};
	// Ack only once the routine is entered; a long delay models a busy core
	always @(posedge clk_sys)
	begin
		fastIrqAck <= 1'b0;
		if (!violationTaken || fastIrqAck)
			waitCnt <= 4'h0;
		else if (waitCnt == ackDelay)
			fastIrqAck <= 1'b1;
		else
			waitCnt <= waitCnt + 4'h1;
	end
endmodule

// ===== verification/memory_address_router_test.sv
// Self-checking bench for the memory address router
`timescale 1ns/10ps
`define CHK(nm, ex, got) \
	begin \
		n_tests++; \
		if ((got) !== (ex)) \
		begin \
			mismatches++; \
			$display("unexpected %s expected %h seen %h", nm, ex, got); \
		end \
	end
module memory_address_router_test;
	logic        clk_sys = 1'b0;
	logic        rst_n = 1'b0;
	logic        progReq = 1'b0, dataReq = 1'b0, copReq = 1'b0, copSelY = 1'b0;
	logic [20:0] program_word_addr = 21'h00_0000;
	logic [21:0] byte_addr_lines = 22'h00_0000;
	logic [15:0] copAddr = 16'h0000;
	logic        icBaseWrite = 1'b0, dcBaseWrite = 1'b0, icMiss = 1'b0, dcMiss = 1'b0;
	logic [23:0] baseData = 24'h00_0000, icB, dcB;
	logic [1:0]  sramBankSel = 2'h0;
	logic [11:0] icMissOffs = 12'h000, dcMissOffs = 12'h000;
	logic        data_side_mover = 1'b0, y_side_mover = 1'b0, moverToExt = 1'b0;
	logic        irqEn = 1'b0;
	logic [3:0]  ackDelay = 4'h0;
	logic [15:0] status_word, rnd = 16'h0047;
	logic        fastIrqAck, fast_irq, violationTaken;
	logic        progToInternal, progToCache, dataToInternal, dataToCache, copToX, copToY;
	logic [23:0] instr_cache_window_base, data_cache_window_base, icExtAddr, dcExtAddr;
	logic        icExtSdram, icExtValid, dcExtSdram, dcExtValid;
	logic        moverIntRead, moverIntWrite, moverExtRead, moverExtWrite;
	logic [24:0] icQ[$], dcQ[$], e;
	int          mismatches = 0, n_tests = 0;

	always #4 clk_sys = ~clk_sys;

	memory_address_router #(.CACHE_OFFS_W(12)) i_dut (.clk_sys, .rst_n, .progReq,
		.program_word_addr, .progToInternal, .progToCache, .dataReq, .byte_addr_lines,
		.dataToInternal, .dataToCache, .copReq, .copSelY, .copAddr, .copToX, .copToY,
		.status_word, .fast_irq, .violationTaken, .fastIrqAck, .icBaseWrite, .dcBaseWrite,
		.baseData, .instr_cache_window_base, .data_cache_window_base, .sramBankSel, .icMiss,
		.icMissOffs, .dcMiss, .dcMissOffs, .icExtAddr, .icExtSdram, .icExtValid, .dcExtAddr,
		.dcExtSdram, .dcExtValid, .data_side_mover, .y_side_mover, .moverToExt,
		.moverIntRead, .moverIntWrite, .moverExtRead, .moverExtWrite);

	core_model i_core (.clk_sys, .irqEn, .ackDelay, .violationTaken, .status_word,
		.fastIrqAck);

	// ==========================================================
	// Helpers
	task automatic getr(output logic [31:0] v);
		rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
		v[31:16] = rnd;
		rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
		v[15:0] = rnd;
	endtask

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic decode(input logic r, input logic [20:0] pa, input logic [21:0] da,
		input logic [15:0] ca, input logic y);
		logic [5:0] x, g;
		@(negedge clk_sys);
		{progReq, dataReq, copReq} = {3{r}};
		program_word_addr = pa;
		byte_addr_lines = da;
		copAddr = ca;
		copSelY = y;
		#1;
		x = {r && pa >= 21'h1F_E000, r && pa < 21'h1F_E000, r && da[21], r && !da[21],
			r && !y && ca < 16'h4000, r && y && ca < 16'h2000};
		g = {progToInternal, progToCache, dataToInternal, dataToCache, copToX, copToY};
		`CHK("select", x, g)
	endtask

	// Bounded wait; running out ends the run
	task automatic wt();
		for (int i = 0; i < 20 && fast_irq !== 1'b0; i++)
			@(negedge clk_sys);
		`CHK("irq clear", 1'b0, fast_irq)
		if (fast_irq !== 1'b0)
			finish_test();
	endtask

	task automatic irq(input logic c, input logic y, input logic [21:0] a, input logic h,
		input logic [3:0] d);
		ackDelay = d;
		irqEn = 1'b1;
		wt();
		irqEn = 1'b0;
		{copReq, dataReq, copSelY, copAddr, byte_addr_lines} = {c, !c, y, a[15:0], a};
		@(negedge clk_sys);
		{copReq, dataReq} = 2'b00;
		`CHK("fast_irq", h, fast_irq)
		repeat (3) @(negedge clk_sys);
		`CHK("not taken", 2'b0 | h, {violationTaken, fast_irq})
		irqEn = 1'b1;
		#1;
		`CHK("taken", h, violationTaken)
		wt();
	endtask

	task automatic wbase(input logic ic, input logic [23:0] v);
		@(negedge clk_sys);
		{icBaseWrite, dcBaseWrite, baseData} = {ic, !ic, v};
		@(negedge clk_sys);
		{icBaseWrite, dcBaseWrite} = 2'b00;
		`CHK("base", v, ic ? instr_cache_window_base : data_cache_window_base)
	endtask

	// ==========================================================
	// Result monitor: each external result takes the oldest note
	always @(negedge clk_sys)
	begin
		if (icExtValid === 1'b1)
		begin
			e = icQ.size() ? icQ.pop_front() : 25'hx;
			`CHK("icExt", e, {icExtSdram, icExtAddr})
		end
		if (dcExtValid === 1'b1)
		begin
			e = dcQ.size() ? dcQ.pop_front() : 25'hx;
			`CHK("dcExt", e, {dcExtSdram, dcExtAddr})
		end
	end

	// ==========================================================
	// Main sequence
	initial
	begin
		logic [31:0] v;
		logic [23:0] s;
		logic        a;
		logic [3:0]  m;
		repeat (10) @(negedge clk_sys);
		rst_n = 1'b1;
		repeat (3) @(negedge clk_sys);
		`CHK("reset", 49'h0, {fast_irq, instr_cache_window_base, data_cache_window_base})
		decode(1'b1, 21'h1F_DFFF, 22'h1F_FFFF, 16'h3FFF, 1'b0);
		decode(1'b1, 21'h1F_E000, 22'h20_0000, 16'h1FFF, 1'b1);
		decode(1'b0, 21'h1F_FFFF, 22'h3F_FFFF, 16'h0000, 1'b0);
		for (int k = 0; k < 24; k++)
		begin
			getr(v);
			decode(1'b1, v[20:0], {v[31], v[20:0]}, v[31:16], v[22]);
		end
		decode(1'b0, 21'h00_0000, 22'h00_0000, 16'h0000, 1'b0);
		$display("decode done");
		irq(1'b1, 1'b0, 22'h00_4000, 1'b1, 4'h0);
		irq(1'b1, 1'b1, 22'h00_2000, 1'b1, 4'h6);
		irq(1'b1, 1'b1, 22'h00_1FFF, 1'b0, 4'h0);
		irq(1'b0, 1'b0, 22'h21_2000, 1'b1, 4'h3);
		irq(1'b0, 1'b0, 22'h21_1FFF, 1'b0, 4'h0);
		$display("fast interrupt done");
		// Second pass sits in the static RAM half and crosses bank and half limits
		for (int p = 0; p < 2; p++)
		begin
			icB = p ? 24'h0F_FFF0 : 24'h80_0000;
			dcB = p ? 24'h7F_FFF0 : 24'hFF_FFF0;
			wbase(1'b1, icB);
			wbase(1'b0, dcB);
			for (int k = 0; k < 12; k++)
			begin
				@(negedge clk_sys);
				getr(v);
				{icMiss, dcMiss, sramBankSel} = {k == 0 || v[31], 1'b1, v[13:12]};
				icMissOffs = (k == 0) ? 12'h005 : v[11:0];
				dcMissOffs = v[27:16];
				s = icB + {12'h000, icMissOffs};
				if (icMiss)
					icQ.push_back({s[23], s});
				s = dcB + {12'h000, dcMissOffs};
				dcQ.push_back({s[23], s});
			end
			@(negedge clk_sys);
			{icMiss, dcMiss} = 2'b00;
			repeat (2) @(negedge clk_sys);
			`CHK("pending", 0, icQ.size() + dcQ.size())
		end
		$display("external address done");
		for (int k = 0; k < 8; k++)
		begin
			@(negedge clk_sys);
			{moverToExt, y_side_mover, data_side_mover} = k[2:0];
			#1;
			a = k[1] | k[0];
			m = {moverIntRead, moverExtWrite, moverExtRead, moverIntWrite};
			`CHK("mover", {a & k[2], a & k[2], a & !k[2], a & !k[2]}, m)
		end
		$display("movers done");
		finish_test();
	end
endmodule
